/* File: verilog/fpd_download_ctrl.v */
// fpd_download_ctrl.v: flash routine download sequencer with its APB register file.
// assumes the cpu reports on cpu_exec_from_ram whether the current store executes
// from on-chip ram, that program storage answers one cycle after its address, and
// that the ram write port takes one byte per cycle.
//
// Notes on behaviour
// (R01) program_routine_select at one chooses the programming routine for download.
// (R02) several routines selected: no copy, source-select error in the result byte.
// (R03) copy starts at the ram address held in the destination register.
// (R04) download_request write of one refused unless key register holds A5.
// (R05) download_request write of one only accepted when executed from on-chip ram.
// (R06) a set download_request starts the download with no further software action.
// (R07) download_request is cleared before the cpu resumes, so never read as one.
// (R08) software loads vector_base_reg with 84000000 before requesting a download.
// (R09) software follows the request store with four no-operation instructions.
// (R10) during a download the user memory space maps the program storage area.
// (R11) selection and destination are checked before the routine is copied.
// (R12) request and both select bits are cleared as part of the download.
// (R13) result code written to the byte at the start of the destination area.
// (R14) software presets the result byte to something other than FF.
// (R15) software judges success only from the result byte.
// (R16) one programming pass writes 128 bytes; larger amounts repeat in steps.
// (R17) software pads short programming data to 128 bytes, preferably with FF.
// (R18) the hardware write-enable pin must be high to program or erase.
// (R19) request writes during a running download are ignored.
`include "fpd_map.vh"
`default_nettype none

module fpd_download_ctrl (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire cpu_exec_from_ram,
  input wire hw_write_enable,
  output reg irq,
  output reg cpu_hold,
  output reg memory_space_swap,
  output reg [7:0] storage_addr,
  input wire [7:0] storage_rdata,
  output reg ram_we,
  output reg [12:0] ram_addr,
  output reg [7:0] ram_wdata
);

  // ********************************
  // state encoding
  // ********************************
  localparam [5:0] ST_IDLE   = 6'b000001;
  localparam [5:0] ST_CHECK  = 6'b000010;
  localparam [5:0] ST_FETCH  = 6'b000100;
  localparam [5:0] ST_STORE  = 6'b001000;
  localparam [5:0] ST_RESULT = 6'b010000;
  localparam [5:0] ST_FINISH = 6'b100000;

  reg [5:0] state_r;
  reg download_request_r;
  reg flash_error_flag_r;
  reg program_routine_select_r;
  reg erase_routine_select_r;
  reg [7:0] protect_key_reg_r;
  reg [6:0] dest_area_field_r;
  reg dest_address_error_r;
  reg [1:0] irq_stat_r;
  reg [1:0] irq_mask_r;
  reg [7:0] result_r;
  reg [7:0] copy_idx_r;
  reg we_meta_r;
  reg we_sync_r;
  reg [31:0] rd_nxt;
  reg rd_err_nxt;

  wire acc = psel & penable & ~pready;
  wire wr_done = psel & penable & pready & pwrite;
  wire [12:0] dest_base = {dest_area_field_r, 6'h00};

  // decode of one register offset against the current bus address
  function hit;
    input [7:0] addr;
    input [7:0] off;
    begin
      hit = (addr == off);
    end
  endfunction

  // destination must leave room for the routine and one 128-byte data pass
  function dest_fits;
    input [6:0] area;
    reg [13:0] end_addr;
    begin
      end_addr = ({1'b0, area, 6'h00}) + {6'h00, `FPD_ROUTINE_LEN} + `FPD_PASS_BYTES;
      dest_fits = (end_addr <= `FPD_RAM_BYTES); // R16
    end
  endfunction

  wire req_write = wr_done & hit(paddr, `FPD_OFF_CCS) & pwdata[`FPD_CCS_REQ_BIT];
  wire req_ok = req_write & (protect_key_reg_r == `FPD_KEY_UNLOCK) // R04
              & cpu_exec_from_ram // R05
              & (state_r == ST_IDLE); // R19
  wire ev_done = (state_r == ST_FINISH);
  wire ev_fail = (state_r == ST_FINISH) & (result_r != `FPD_RES_OK);

  // ********************************
  // pin synchroniser
  // ********************************
  // the write-enable pin is asynchronous; second stage is the only reader of the first
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      we_meta_r <= 1'b0;
      we_sync_r <= 1'b0;
    end else begin
      we_meta_r <= hw_write_enable;
      we_sync_r <= we_meta_r;
    end
  end

  // ********************************
  // apb read mux
  // ********************************
  // unmapped offsets answer zero with pslverr
  always @* begin
    rd_nxt = `FPD_RD_ZERO;
    rd_err_nxt = 1'b0;
    case (paddr)
      `FPD_OFF_CCS: begin
        rd_nxt[`FPD_CCS_WE_BIT] = we_sync_r;
        rd_nxt[`FPD_CCS_ERR_BIT] = flash_error_flag_r;
        rd_nxt[`FPD_CCS_REQ_BIT] = download_request_r;
      end
      `FPD_OFF_PSEL: rd_nxt[`FPD_SEL_BIT] = program_routine_select_r;
      `FPD_OFF_ESEL: rd_nxt[`FPD_SEL_BIT] = erase_routine_select_r;
      `FPD_OFF_KEY: rd_nxt[7:0] = protect_key_reg_r;
      `FPD_OFF_DEST: rd_nxt[7:0] = {dest_address_error_r, dest_area_field_r};
      `FPD_OFF_IRQ_STAT: rd_nxt[1:0] = irq_stat_r;
      `FPD_OFF_IRQ_MASK: rd_nxt[1:0] = irq_mask_r;
      default: rd_err_nxt = 1'b1;
    endcase
  end

  // one wait state: pready rises in the second access cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= `FPD_RD_ZERO;
    end else begin
      pready <= acc;
      pslverr <= acc & rd_err_nxt;
      if (acc & ~pwrite) begin
        prdata <= rd_nxt;
      end
    end
  end

  // ********************************
  // software registers
  // ********************************
  // the sequencer clears its bits in the finish state; a bus write there loses
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      download_request_r <= 1'b0;
      program_routine_select_r <= 1'b0;
      erase_routine_select_r <= 1'b0;
      protect_key_reg_r <= `FPD_RST_BYTE;
      dest_area_field_r <= 7'h00;
      irq_mask_r <= `FPD_RST_IRQ;
    end else begin
      if (req_ok) begin
        download_request_r <= 1'b1; // R06
      end else if (state_r == ST_FINISH) begin
        download_request_r <= 1'b0; // R07 R12
      end
      if (state_r == ST_FINISH) begin
        program_routine_select_r <= 1'b0; // R12
        erase_routine_select_r <= 1'b0; // R12
      end else if (wr_done & (state_r == ST_IDLE)) begin
        if (hit(paddr, `FPD_OFF_PSEL)) begin
          program_routine_select_r <= pwdata[`FPD_SEL_BIT]; // R01
        end
        if (hit(paddr, `FPD_OFF_ESEL)) begin
          erase_routine_select_r <= pwdata[`FPD_SEL_BIT];
        end
      end
      if (wr_done & hit(paddr, `FPD_OFF_KEY)) begin
        protect_key_reg_r <= pwdata[7:0];
      end
      if (wr_done & hit(paddr, `FPD_OFF_DEST) & (state_r == ST_IDLE)) begin
        dest_area_field_r <= pwdata[6:0]; // R03
      end
      if (wr_done & hit(paddr, `FPD_OFF_IRQ_MASK)) begin
        irq_mask_r <= pwdata[1:0];
      end
    end
  end

  // ********************************
  // interrupt status
  // ********************************
  // write one to clear; a fresh event in the same cycle keeps its bit set
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_r <= `FPD_RST_IRQ;
      irq <= 1'b0;
    end else begin
      if (wr_done & hit(paddr, `FPD_OFF_IRQ_STAT)) begin
        irq_stat_r <= (irq_stat_r & ~pwdata[1:0]) | {ev_fail, ev_done};
      end else begin
        irq_stat_r <= irq_stat_r | {ev_fail, ev_done};
      end
      irq <= |(irq_stat_r & irq_mask_r);
    end
  end

  // ********************************
  // download sequencer
  // ********************************
  // cpu is held for the whole download, which is why it never sees the request set
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= ST_IDLE;
      result_r <= `FPD_RES_OK;
      copy_idx_r <= `FPD_ZERO_SRC;
      dest_address_error_r <= 1'b0;
      flash_error_flag_r <= 1'b0;
      cpu_hold <= 1'b0;
      memory_space_swap <= 1'b0;
      storage_addr <= `FPD_ZERO_SRC;
      ram_we <= 1'b0;
      ram_addr <= `FPD_ZERO_ADDR;
      ram_wdata <= `FPD_RST_BYTE;
    end else begin
      ram_we <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          if (req_ok) begin
            cpu_hold <= 1'b1; // R06
            memory_space_swap <= 1'b1; // R10
            state_r <= ST_CHECK;
          end
        end
        ST_CHECK: begin
          copy_idx_r <= `FPD_ZERO_SRC;
          dest_address_error_r <= ~dest_fits(dest_area_field_r); // R11
          if (program_routine_select_r & erase_routine_select_r) begin
            result_r <= `FPD_RES_SS_ERR; // R02
            state_r <= ST_RESULT;
          end else if (~program_routine_select_r & ~erase_routine_select_r) begin
            result_r <= `FPD_RES_SS_ERR;
            state_r <= ST_RESULT;
          end else if (~dest_fits(dest_area_field_r)) begin
            result_r <= `FPD_RES_DEST_ERR; // R11
            state_r <= ST_RESULT;
          end else begin
            result_r <= `FPD_RES_OK;
            storage_addr <= `FPD_ZERO_SRC;
            state_r <= ST_FETCH;
          end
        end
        ST_FETCH: begin
          // storage data is valid one cycle after its address
          state_r <= ST_STORE;
        end
        ST_STORE: begin
          ram_we <= 1'b1;
          ram_addr <= dest_base + {5'h00, copy_idx_r}; // R03 R11
          ram_wdata <= storage_rdata;
          copy_idx_r <= copy_idx_r + `FPD_ONE_SRC;
          storage_addr <= copy_idx_r + `FPD_ONE_SRC;
          if (copy_idx_r == `FPD_ROUTINE_LEN - `FPD_ONE_SRC) begin
            state_r <= ST_RESULT;
          end else begin
            state_r <= ST_FETCH;
          end
        end
        ST_RESULT: begin
          ram_we <= 1'b1;
          ram_addr <= dest_base; // R13
          ram_wdata <= result_r; // R13
          flash_error_flag_r <= (result_r != `FPD_RES_OK);
          state_r <= ST_FINISH;
        end
        ST_FINISH: begin
          memory_space_swap <= 1'b0;
          cpu_hold <= 1'b0; // R07
          state_r <= ST_IDLE;
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

endmodule // fpd_download_ctrl

`default_nettype wire

/* File: verilog/fpd_map.vh */
// fpd_map.vh: register offsets, field positions, reset values and sequencer constants
// for the flash program download control block; assumes a 32-bit APB bus on pclk.
`ifndef FPD_MAP_VH
`define FPD_MAP_VH

// ********************************
// register byte offsets
// ********************************
`define FPD_OFF_CCS       8'h00
`define FPD_OFF_PSEL      8'h04
`define FPD_OFF_ESEL      8'h08
`define FPD_OFF_KEY       8'h0C
`define FPD_OFF_DEST      8'h10
`define FPD_OFF_IRQ_STAT  8'h14
`define FPD_OFF_IRQ_MASK  8'h18

// ********************************
// field positions
// ********************************
`define FPD_CCS_WE_BIT    7
`define FPD_CCS_ERR_BIT   4
`define FPD_CCS_REQ_BIT   0
`define FPD_SEL_BIT       0
`define FPD_DEST_ERR_BIT  7
`define FPD_IRQ_DONE_BIT  0
`define FPD_IRQ_FAIL_BIT  1

// ********************************
// values
// ********************************
`define FPD_KEY_UNLOCK    8'hA5
`define FPD_RST_BYTE      8'h00
`define FPD_RST_IRQ       2'h0
`define FPD_RES_OK        8'h00
`define FPD_RES_SS_ERR    8'h01
`define FPD_RES_DEST_ERR  8'h02
`define FPD_RD_ZERO       32'h0000_0000

// ********************************
// download geometry
// ********************************
`define FPD_ROUTINE_LEN   8'h80
`define FPD_PASS_BYTES    14'h0080
`define FPD_RAM_BYTES     14'h2000
`define FPD_DEST_SHIFT    6
`define FPD_ZERO_ADDR     13'h0000
`define FPD_ONE_ADDR      13'h0001
`define FPD_ZERO_SRC      8'h00
`define FPD_ONE_SRC       8'h01

`endif

/* File: test/fpd_mem_model.sv */
// fpd_mem_model.sv: program storage and on-chip ram seen by the download block.
// assumes storage data is read combinationally and ram takes one byte per edge.
`default_nettype none
module fpd_mem_model (
  input wire logic pclk,
  input wire logic memory_space_swap,
  input wire logic [7:0] storage_addr,
  output logic [7:0] storage_rdata,
  input wire logic ram_we,
  input wire logic [12:0] ram_addr,
  input wire logic [7:0] ram_wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] ram [0:8191];
  // routine image shows only while mapped in; otherwise a scrambled pattern
  // the image is a whole 128-byte block, so the cpu side never needs padding
  assign storage_rdata = memory_space_swap ? storage_addr * 8'h03 + 8'h11 : ~(storage_addr ^ 8'h3C);
  // one byte per write pulse
  always @(posedge pclk) if (ram_we) ram[ram_addr] <= ram_wdata;
endmodule // fpd_mem_model
`default_nettype wire

/* File: test/fpd_download_ctrl_checker.sv */
// fpd_download_ctrl_checker.sv: bus and sequencer assertions for the download block.
// assumes only the top ports are seen; key mirrored from completed writes.
`default_nettype none
module fpd_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic cpu_exec_from_ram,
  input wire logic cpu_hold,
  input wire logic memory_space_swap,
  input wire logic ram_we
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] key_r;
  logic wr_req;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // key copy; the key register itself is never refused
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) key_r <= 8'h00;
    else if (psel && penable && pready && pwrite && paddr == 8'h0C) key_r <= pwdata[7:0];
  end
  assign wr_req = psel && penable && pready && pwrite && paddr == 8'h00 && pwdata[0];
  sequence s_req_ok;
    wr_req && key_r == 8'hA5 && cpu_exec_from_ram && !cpu_hold;
  endsequence
  AST_START: assert property (s_req_ok |=> cpu_hold && memory_space_swap) else $error("download not started");
  AST_KEY: assert property (wr_req && key_r != 8'hA5 && !cpu_hold |=> !cpu_hold) else $error("key ignored");
  AST_RAM: assert property (wr_req && !cpu_exec_from_ram && !cpu_hold |=> !cpu_hold) else $error("fetch");
  AST_END: assert property ($rose(cpu_hold) |-> ##[2:300] !cpu_hold) else $error("download hangs");
  AST_SWAP: assert property (cpu_hold == memory_space_swap) else $error("swap differs from hold");
  AST_WE: assert property (ram_we |-> cpu_hold || $past(cpu_hold)) else $error("stray ram write");
  AST_WAIT: assert property (psel && penable && !pready |=> pready) else $error("wait state wrong");
  AST_PULSE: assert property (pready |=> !pready) else $error("ready too long");
  AST_ERR: assert property (pslverr |-> pready) else $error("error without ready");
endmodule // fpd_chk
bind fpd_download_ctrl fpd_chk chk(.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
  .pslverr, .cpu_exec_from_ram, .cpu_hold, .memory_space_swap, .ram_we);
`default_nettype wire

/* File: test/test_flash_program_download_control.sv */
// test_flash_program_download_control.sv: self-checking bench for the download block.
// assumes the design answers the bus with one wait state; storage and ram are modelled.
`include "fpd_map.vh"
`default_nettype none
module test_flash_program_download_control;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [32:0] OK = 33'h0;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, cpu_exec_from_ram = 1, hw_write_enable = 1;
  logic m = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, lf = 32'h8A2004D7;
  logic pready, pslverr, irq, cpu_hold, memory_space_swap, ram_we;
  logic [7:0] storage_addr, storage_rdata, ram_wdata;
  logic [12:0] ram_addr;
  logic [32:0] expq[$];
  int bad_count = 0, total_checks = 0;
  fpd_download_ctrl dut(.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .cpu_exec_from_ram, .hw_write_enable, .irq, .cpu_hold, .memory_space_swap, .storage_addr, .storage_rdata,
    .ram_we, .ram_addr, .ram_wdata);
  fpd_mem_model mem(.pclk, .memory_space_swap, .storage_addr, .storage_rdata, .ram_we, .ram_addr, .ram_wdata);
  always #2.5 pclk = ~pclk;
  // ********************************
  // helpers
  // ********************************
  // next value of the stimulus shift register; feeds destination areas into pwdata
  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic cmp(input string n, input logic [32:0] e, input logic [32:0] s);
    total_checks++;
    if (s !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  // one transfer; an idle edge first so psel never changes twice in a step
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
    int n;
    n = 0;
    expq.push_back(e);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    psel <= 0;
    penable <= 0;
    if (n == 20) bad_count++;
  endtask
  // result watcher: oldest expectation against each completed transfer
  always @(posedge pclk) if (psel && penable && pready === 1'b1) begin
    if (expq.size() == 0) bad_count++;
    else cmp("bus", expq.pop_front(), {pslverr, pwrite ? 32'h0 : prdata});
  end
  task automatic download(input logic [6:0] a, input logic [1:0] s, input logic [7:0] r);
    int n;
    logic [12:0] b;
    n = 0;
    b = {a, 6'h00};
    mem.ram[b] = 8'h55;
    bus(1, `FPD_OFF_PSEL, 32'(s[0]), OK);
    bus(1, `FPD_OFF_ESEL, 32'(s[1]), OK);
    bus(1, `FPD_OFF_DEST, 32'(a), OK);
    // cpu side: vector base already loaded, the no-ops after this store run under the hold
    bus(1, `FPD_OFF_CCS, 32'h1, OK);
    if (r == `FPD_RES_OK) begin
      bus(1, `FPD_OFF_DEST, 32'(~a), OK);
      bus(1, `FPD_OFF_CCS, 32'h1, OK);
    end
    // the hold rises at the completing edge, so let it become visible before waiting on it
    repeat (2) @(posedge pclk);
    while (cpu_hold !== 1'b0 && n < 400) begin
      @(posedge pclk);
      n++;
    end
    cmp("hold", OK, 33'(cpu_hold));
    cmp("result", 33'(r), 33'(mem.ram[b]));
    if (r == `FPD_RES_OK) begin
      for (int i = 1; i < 128; i++) cmp("copy", 33'(8'(i * 8'h03 + 8'h11)), 33'(mem.ram[b + i]));
    end
    bus(0, `FPD_OFF_CCS, 32'h0, r == `FPD_RES_OK ? 33'h80 : 33'h90);
    bus(0, `FPD_OFF_PSEL, 32'h0, OK);
    bus(0, `FPD_OFF_ESEL, 32'h0, OK);
    bus(0, `FPD_OFF_DEST, 32'h0, {25'h0, r == `FPD_RES_DEST_ERR, a});
    bus(0, `FPD_OFF_IRQ_STAT, 32'h0, r == `FPD_RES_OK ? 33'h1 : 33'h3);
    cmp("irq", 33'(m), 33'(irq));
    bus(1, `FPD_OFF_IRQ_STAT, 32'h3, OK);
    repeat (3) @(posedge pclk);
    cmp("irq", OK, 33'(irq));
    $display("test download %h done", r);
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // ********************************
  // scenarios
  // ********************************
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1;
    for (int i = 0; i < 8; i++) bus(0, 8'(i * 4), 32'h0, {i == 7, i == 0 ? 32'h80 : 32'h0});
    bus(1, 8'h1C, 32'hFF, 33'h1_0000_0000);
    $display("test reset_map done");
    bus(1, `FPD_OFF_PSEL, 32'h1, OK);
    bus(1, `FPD_OFF_CCS, 32'h1, OK);
    bus(0, `FPD_OFF_CCS, 32'h0, 33'h80);
    bus(1, `FPD_OFF_KEY, 32'hA5, OK);
    cpu_exec_from_ram <= 0;
    bus(1, `FPD_OFF_CCS, 32'h1, OK);
    bus(0, `FPD_OFF_CCS, 32'h0, 33'h80);
    cpu_exec_from_ram <= 1;
    // pin low must read back as zero once it has crossed the synchroniser
    hw_write_enable <= 0;
    repeat (2) @(posedge pclk);
    bus(0, `FPD_OFF_CCS, 32'h0, OK);
    hw_write_enable <= 1;
    repeat (2) @(posedge pclk);
    $display("test refusals done");
    lf = lfsr_next(lf);
    download(7'(lf % 125), 2'h1, `FPD_RES_OK);
    bus(1, `FPD_OFF_IRQ_MASK, 32'h3, OK);
    m = 1;
    download(7'h7C, 2'h1, `FPD_RES_OK);
    lf = lfsr_next(lf);
    download(7'(lf % 100), 2'h3, `FPD_RES_SS_ERR);
    download(7'h05, 2'h0, `FPD_RES_SS_ERR);
    download(7'h7D, 2'h1, `FPD_RES_DEST_ERR);
    complete_run;
  end
  // watchdog, about twelve times the expected run
  initial begin
    #50000;
    bad_count++;
    complete_run;
  end
endmodule // test_flash_program_download_control
`default_nettype wire
